// file: logic/pcfc_regs.vh
`ifndef PCFC_REGS_VH
`define PCFC_REGS_VH

// register offsets on the plain port
`define PCFC_OFS_A 8'h00
`define PCFC_OFS_P 8'h04
`define PCFC_OFS_Q 8'h08
`define PCFC_OFS_X 8'h0C
`define PCFC_OFS_SHIFT 8'h10
`define PCFC_OFS_INSTR 8'h14
`define PCFC_OFS_TARGET 8'h18
`define PCFC_OFS_STATUS 8'h1C
`define PCFC_OFS_FLAGS 8'h20

// status field positions
`define PCFC_ST_IN_WORD 0
`define PCFC_ST_IN_REC 1
`define PCFC_ST_OUT_WORD 2
`define PCFC_ST_OUT_REC 3
`define PCFC_ST_RESUME 4
`define PCFC_ST_PARITY 5
`define PCFC_ST_BUSY 6
`define PCFC_ST_JUMP 7
`define PCFC_ST_CYCLE_LO 8

// reset values
`define PCFC_RST_A 18'h00000
`define PCFC_RST_12 12'h000
`define PCFC_RST_X 13'h0000
`define PCFC_RST_SHIFT 6'h00
`define PCFC_RST_RESUME 1'b1

// function codes in the upper six bits of the instruction word
`define PCFC_F_JUMP_HI 3'h6
`define PCFC_F_IN 6'h38
`define PCFC_F_BLK_IN 6'h39
`define PCFC_F_OUT 6'h3A
`define PCFC_F_BLK_OUT 6'h3B
`define PCFC_F_REC 6'h3C
`define PCFC_F_ADD 6'h10
`define PCFC_F_LOAD 6'h11
`define PCFC_F_STORE 6'h12
`define PCFC_F_SHIFT 6'h13

// shift distance wrap for circular shift
`define PCFC_A_WIDTH 5'h12

`endif

// file: logic/pcfc_mem.v
`timescale 1ns/1ps
`default_nettype none
module pcfc_mem (
	input wire clk,
	input wire rst,
	input wire we,
	input wire re,
	input wire [11:0] addr,
	input wire [11:0] wdata,
	output reg [12:0] rdata_q,
	output reg perr_q
);
	wire [25:0] rd_all;
	wire [12:0] rd_word;
	genvar b;

	generate
		for (b = 0; b < 2; b = b + 1) begin : g_bank
			// two stacks of 2048 words, picked by the low address bit
			reg [12:0] store [0:2047];
			always @(posedge clk) begin
				if (we && addr[0] == b) begin
					store[addr[11:1]] <= {~^wdata, wdata};
				end
			end
			assign rd_all[b*13 +: 13] = store[addr[11:1]];
		end
	endgenerate

	// consecutive addresses fall in alternate banks
	assign rd_word = addr[0] ? rd_all[25:13] : rd_all[12:0];

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 13'h0000;
			perr_q <= 1'b0;
		end else begin
			if (re) begin
				rdata_q <= rd_word;
			end
			// odd parity: an even count of ones is an error
			perr_q <= re & ~(^rd_word);
		end
	end
endmodule
`default_nettype wire

// file: logic/pcfc_top.v
// Overview of operation
// - 18-bit operand register holds an operand and every result, bit 17 is sign.
// - Arithmetic ignores overflow and folds the carry back into the low end.
// - Block input and output keep the remaining length in the operand register.
// - Single-word input loads the 12-bit word; single output sends operand bits.
// - Program address steps one or two, or loads the target on a jump.
// - Operand address register holds the address, then the top six operand bits.
// - 13-bit memory data register captures reads and the low 12 operand bits.
// - Shift count: low five bits distance, top bit picks circular left or end-off right.
// - Instruction word holds function code high and designator low.
// - 3-bit cycle counter counts memory references of an instruction.
// - 4096 words of 13 bits in two banks, consecutive addresses alternate.
// - Odd parity is stored with each word, checked on read, error flagged.
// - Each channel carries 12 data bits, word and record pulses, resume back.
// - One of eight channels active, chosen by low three designator bits.
// - Input word flag: set by word pulse, cleared on accept, tested by 60/61.
// - Input record flag: set by record pulse, cleared on accept, tested by 62/63.
// - Input resume flag lasts one clock per accept and drives resume; reset sets it.
// - Output channel data holds until this processor replaces it.
// - Word pulse of one clock sets output word flag; resume clears; tested 64/65.
// - Record pulse of one clock sets output record flag; resume clears; tested 66/67.
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_regs.vh"
module pcfc_top (
	input wire REF_CLK,
	input wire RESET,
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [31:0] RDATA,
	input wire [95:0] IN_DATA,
	input wire [7:0] IN_WORD,
	input wire [7:0] IN_RECORD,
	output wire [7:0] IN_RESUME,
	output wire [95:0] OUT_DATA,
	output wire [7:0] OUT_WORD,
	output wire [7:0] OUT_RECORD,
	input wire [7:0] OUT_RESUME,
	output wire PARITY_ERROR
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_EXEC = 3'h1;
	localparam [2:0] S_RD1 = 3'h2;
	localparam [2:0] S_RD2 = 3'h3;
	localparam [2:0] S_SUM = 3'h4;
	localparam [2:0] S_BOUT_RD = 3'h5;

	reg [2:0] state_q, state_d;
	reg [17:0] a_q, a_d;
	reg [11:0] p_q, p_d;
	reg [11:0] q_q, q_d;
	reg [12:0] x_q, x_d;
	reg [5:0] sk_q, sk_d;
	reg [11:0] fd_q, fd_d;
	reg [11:0] target_q, target_d;
	reg [2:0] k_q, k_d;
	reg jump_q, jump_d;
	reg perr_flag_q, perr_flag_d;
	reg [31:0] rd_d;
	reg accept_en, send_word_en, send_rec_en;
	reg mem_we, mem_re;
	reg [11:0] mem_addr;

	wire [12:0] mem_rdata;
	wire mem_perr;
	wire [7:0] in_word_flag;
	wire [7:0] in_rec_flag;
	wire [7:0] in_resume_flag;
	wire [7:0] out_word_flag;
	wire [7:0] out_rec_flag;

	wire [5:0] f_code = fd_q[11:6];
	wire [2:0] ch = fd_q[2:0];
	wire [7:0] ch_sel = 8'h01 << ch;
	wire [6:0] ch_base = {4'h0, ch} * 7'h0C;
	wire [11:0] in_sel = IN_DATA[ch_base +: 12];
	wire [3:0] flag_set = {out_rec_flag[ch], out_word_flag[ch], in_rec_flag[ch], in_word_flag[ch]};
	wire jump_cond = flag_set[f_code[2:1]] ^ f_code[0];
	wire busy = state_q != S_IDLE;
	wire [11:0] out_value = (state_q == S_BOUT_RD) ? mem_rdata[11:0] : a_q[11:0];
	wire [7:0] accept = ch_sel & {8{accept_en}};
	wire [7:0] send_word = ch_sel & {8{send_word_en}};
	wire [7:0] send_rec = ch_sel & {8{send_rec_en}};

	// ones' complement add of the split 18-bit operand
	wire [17:0] operand = {q_q[5:0], x_q[11:0]};
	wire [18:0] add_raw = {1'b0, a_q} + {1'b0, operand};
	wire [17:0] add_res = add_raw[17:0] + {17'h00000, add_raw[18]};

	// circular distance wraps at the register width
	wire [4:0] sh_n = sk_q[4:0];
	wire [4:0] sh_m = (sh_n >= `PCFC_A_WIDTH) ? sh_n - `PCFC_A_WIDTH : sh_n;
	wire [35:0] rot = {a_q, a_q} << sh_m;
	wire [17:0] shift_res = sk_q[5] ? (a_q >> sh_n) : rot[35:18];

	pcfc_mem u_mem (
		.clk(REF_CLK),
		.rst(RESET),
		.we(mem_we),
		.re(mem_re),
		.addr(mem_addr),
		.wdata(mem_we && state_q == S_EXEC && f_code == `PCFC_F_BLK_IN ? in_sel : a_q[11:0]),
		.rdata_q(mem_rdata),
		.perr_q(mem_perr)
	);

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_chan
			reg iw_s1_q, iw_s2_q, ir_s1_q, ir_s2_q, or_s1_q, or_s2_q;
			reg in_word_q, in_rec_q, resume_q, out_word_q, out_rec_q;
			reg word_pulse_q, rec_pulse_q;
			reg [11:0] out_data_q;
			// edges of registered inputs, one event per pulse
			wire iw_edge = iw_s1_q & ~iw_s2_q;
			wire ir_edge = ir_s1_q & ~ir_s2_q;
			wire or_edge = or_s1_q & ~or_s2_q;

			always @(posedge REF_CLK or posedge RESET) begin
				if (RESET) begin
					iw_s1_q <= 1'b0;
					iw_s2_q <= 1'b0;
					ir_s1_q <= 1'b0;
					ir_s2_q <= 1'b0;
					or_s1_q <= 1'b0;
					or_s2_q <= 1'b0;
					in_word_q <= 1'b0;
					in_rec_q <= 1'b0;
					resume_q <= `PCFC_RST_RESUME;
					out_word_q <= 1'b0;
					out_rec_q <= 1'b0;
					word_pulse_q <= 1'b0;
					rec_pulse_q <= 1'b0;
					out_data_q <= `PCFC_RST_12;
				end else begin
					iw_s1_q <= IN_WORD[i];
					iw_s2_q <= iw_s1_q;
					ir_s1_q <= IN_RECORD[i];
					ir_s2_q <= ir_s1_q;
					or_s1_q <= OUT_RESUME[i];
					or_s2_q <= or_s1_q;
					// a new pulse wins over a clear in the same cycle
					in_word_q <= iw_edge | (in_word_q & ~accept[i]);
					in_rec_q <= ir_edge | (in_rec_q & ~accept[i]);
					resume_q <= accept[i];
					out_word_q <= send_word[i] | (out_word_q & ~or_edge);
					out_rec_q <= send_rec[i] | (out_rec_q & ~or_edge);
					word_pulse_q <= send_word[i];
					rec_pulse_q <= send_rec[i];
					if (send_word[i]) begin
						out_data_q <= out_value;
					end
				end
			end

			assign in_word_flag[i] = in_word_q;
			assign in_rec_flag[i] = in_rec_q;
			assign in_resume_flag[i] = resume_q;
			assign out_word_flag[i] = out_word_q;
			assign out_rec_flag[i] = out_rec_q;
			assign IN_RESUME[i] = resume_q;
			assign OUT_WORD[i] = word_pulse_q;
			assign OUT_RECORD[i] = rec_pulse_q;
			assign OUT_DATA[i*12 +: 12] = out_data_q;
		end
	endgenerate

	assign PARITY_ERROR = perr_flag_q;

	always @* begin
		state_d = state_q;
		a_d = a_q;
		p_d = p_q;
		q_d = q_q;
		x_d = x_q;
		sk_d = sk_q;
		fd_d = fd_q;
		target_d = target_q;
		k_d = k_q;
		jump_d = jump_q;
		accept_en = 1'b0;
		send_word_en = 1'b0;
		send_rec_en = 1'b0;
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_addr = q_q;
		// sticky; a parity error in the clearing cycle survives
		perr_flag_d = mem_perr | perr_flag_q;
		if (WR && ADDR == `PCFC_OFS_STATUS && WDATA[`PCFC_ST_PARITY]) begin
			perr_flag_d = mem_perr;
		end
		if (WR) begin
			if (ADDR == `PCFC_OFS_A) begin
				a_d = WDATA[17:0];
			end else if (ADDR == `PCFC_OFS_P) begin
				p_d = WDATA[11:0];
			end else if (ADDR == `PCFC_OFS_Q) begin
				q_d = WDATA[11:0];
			end else if (ADDR == `PCFC_OFS_SHIFT) begin
				sk_d = WDATA[5:0];
			end else if (ADDR == `PCFC_OFS_TARGET) begin
				target_d = WDATA[11:0];
			end else if (ADDR == `PCFC_OFS_INSTR && !busy) begin
				fd_d = WDATA[11:0];
				k_d = 3'h0;
				state_d = S_EXEC;
			end
		end
		case (state_q)
			S_IDLE: begin
				// only an instruction write above leaves idle
			end
			S_EXEC: begin
				if (f_code[5:3] == `PCFC_F_JUMP_HI) begin
					jump_d = jump_cond;
					p_d = jump_cond ? target_q : p_q + 12'h002;
					state_d = S_IDLE;
				end else if (f_code == `PCFC_F_IN) begin
					// waits here until a word has arrived
					if (in_word_flag[ch]) begin
						a_d = {6'h00, in_sel};
						accept_en = 1'b1;
						p_d = p_q + 12'h001;
						state_d = S_IDLE;
					end
				end else if (f_code == `PCFC_F_BLK_IN) begin
					if (a_q == 18'h00000 || (!in_word_flag[ch] && in_rec_flag[ch])) begin
						p_d = p_q + 12'h002;
						state_d = S_IDLE;
					end else if (in_word_flag[ch]) begin
						mem_we = 1'b1;
						accept_en = 1'b1;
						a_d = a_q - 18'h00001;
						q_d = q_q + 12'h001;
						k_d = k_q + 3'h1;
					end
				end else if (f_code == `PCFC_F_OUT) begin
					send_word_en = 1'b1;
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end else if (f_code == `PCFC_F_BLK_OUT) begin
					// next word only after the partner resumed the last
					if (a_q == 18'h00000) begin
						send_rec_en = 1'b1;
						p_d = p_q + 12'h002;
						state_d = S_IDLE;
					end else if (!out_word_flag[ch]) begin
						mem_re = 1'b1;
						k_d = k_q + 3'h1;
						state_d = S_BOUT_RD;
					end
				end else if (f_code == `PCFC_F_REC) begin
					send_rec_en = 1'b1;
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end else if (f_code == `PCFC_F_ADD || f_code == `PCFC_F_LOAD) begin
					mem_re = 1'b1;
					k_d = k_q + 3'h1;
					state_d = S_RD1;
				end else if (f_code == `PCFC_F_STORE) begin
					mem_we = 1'b1;
					k_d = k_q + 3'h1;
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end else if (f_code == `PCFC_F_SHIFT) begin
					a_d = shift_res;
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end else begin
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end
			end
			S_RD1: begin
				x_d = mem_rdata;
				if (f_code == `PCFC_F_LOAD) begin
					a_d = {6'h00, mem_rdata[11:0]};
					p_d = p_q + 12'h001;
					state_d = S_IDLE;
				end else begin
					// upper six operand bits now sit low in the address register
					q_d = {6'h00, mem_rdata[5:0]};
					mem_addr = q_q + 12'h001;
					mem_re = 1'b1;
					k_d = k_q + 3'h1;
					state_d = S_RD2;
				end
			end
			S_RD2: begin
				x_d = mem_rdata;
				state_d = S_SUM;
			end
			S_SUM: begin
				a_d = add_res;
				p_d = p_q + 12'h001;
				state_d = S_IDLE;
			end
			S_BOUT_RD: begin
				x_d = mem_rdata;
				send_word_en = 1'b1;
				a_d = a_q - 18'h00001;
				q_d = q_q + 12'h001;
				state_d = S_EXEC;
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
	end

	always @* begin
		rd_d = 32'h00000000;
		if (ADDR == `PCFC_OFS_A) begin
			rd_d = {14'h0000, a_q};
		end else if (ADDR == `PCFC_OFS_P) begin
			rd_d = {20'h00000, p_q};
		end else if (ADDR == `PCFC_OFS_Q) begin
			rd_d = {20'h00000, q_q};
		end else if (ADDR == `PCFC_OFS_X) begin
			rd_d = {19'h00000, x_q};
		end else if (ADDR == `PCFC_OFS_SHIFT) begin
			rd_d = {26'h0000000, sk_q};
		end else if (ADDR == `PCFC_OFS_INSTR) begin
			rd_d = {20'h00000, fd_q};
		end else if (ADDR == `PCFC_OFS_TARGET) begin
			rd_d = {20'h00000, target_q};
		end else if (ADDR == `PCFC_OFS_STATUS) begin
			rd_d = {21'h000000, k_q, jump_q, busy, perr_flag_q, in_resume_flag[ch], flag_set};
		end else if (ADDR == `PCFC_OFS_FLAGS) begin
			rd_d = {out_rec_flag, out_word_flag, in_rec_flag, in_word_flag};
		end
	end

	always @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_q <= S_IDLE;
			a_q <= `PCFC_RST_A;
			p_q <= `PCFC_RST_12;
			q_q <= `PCFC_RST_12;
			x_q <= `PCFC_RST_X;
			sk_q <= `PCFC_RST_SHIFT;
			fd_q <= `PCFC_RST_12;
			target_q <= `PCFC_RST_12;
			k_q <= 3'h0;
			jump_q <= 1'b0;
			perr_flag_q <= 1'b0;
			RDATA <= 32'h00000000;
		end else begin
			state_q <= state_d;
			a_q <= a_d;
			p_q <= p_d;
			q_q <= q_d;
			x_q <= x_d;
			sk_q <= sk_d;
			fd_q <= fd_d;
			target_q <= target_d;
			k_q <= k_d;
			jump_q <= jump_d;
			perr_flag_q <= perr_flag_d;
			RDATA <= RD ? rd_d : 32'h00000000;
		end
	end
endmodule
`default_nettype wire

// file: sim/pcfc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_regs.vh"
module pcfc_monitor (
	input wire REF_CLK,
	input wire RESET,
	input wire [7:0] ADDR,
	input wire [31:0] WDATA,
	input wire WR,
	input wire [7:0] IN_RESUME,
	input wire [95:0] OUT_DATA,
	input wire [7:0] OUT_WORD,
	input wire [7:0] OUT_RECORD,
	input wire PARITY_ERROR
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);
	word_pulse_a: assert property (|OUT_WORD |=> (OUT_WORD & $past(OUT_WORD)) == 8'h00)
		else $error("word pulse longer than one cycle");
	rec_pulse_a: assert property (|OUT_RECORD |=> (OUT_RECORD & $past(OUT_RECORD)) == 8'h00)
		else $error("record pulse longer than one cycle");
	resume_pulse_a: assert property (|IN_RESUME |=> (IN_RESUME & $past(IN_RESUME)) == 8'h00)
		else $error("resume pulse longer than one cycle");
	one_channel_a: assert property (!$past(RESET) |->
		$onehot0(OUT_WORD) && $onehot0(OUT_RECORD) && $onehot0(IN_RESUME))
		else $error("more than one channel active");
	data_hold_a: assert property (!$stable(OUT_DATA) |-> |OUT_WORD)
		else $error("output data changed without a send");
	parity_sticky_a: assert property (PARITY_ERROR &&
		!(WR && ADDR == `PCFC_OFS_STATUS && WDATA[`PCFC_ST_PARITY]) |=> PARITY_ERROR)
		else $error("parity error dropped without clear");
	word_launch_a: assert property (WR && ADDR == `PCFC_OFS_INSTR && WDATA[11:6] == `PCFC_F_OUT
		|-> ##2 OUT_WORD == 8'h01 << $past(WDATA[2:0], 2))
		else $error("output word pulse missing or on wrong channel");
	rec_launch_a: assert property (WR && ADDR == `PCFC_OFS_INSTR && WDATA[11:6] == `PCFC_F_REC
		|-> ##2 OUT_RECORD == 8'h01 << $past(WDATA[2:0], 2))
		else $error("record pulse missing or on wrong channel");
	cover property (|OUT_WORD);
	cover property (|OUT_RECORD);
	cover property (|IN_RESUME);
endmodule
bind pcfc_top pcfc_monitor u_mon (.REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .IN_RESUME(IN_RESUME), .OUT_DATA(OUT_DATA), .OUT_WORD(OUT_WORD),
	.OUT_RECORD(OUT_RECORD), .PARITY_ERROR(PARITY_ERROR));
`default_nettype wire

// file: sim/pcfc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module pcfc_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] out_word,
	input wire logic [7:0] out_record,
	input wire logic [7:0] in_resume,
	input wire logic [3:0] lag,
	input wire logic send_word,
	input wire logic send_rec,
	input wire logic [2:0] chan,
	input wire logic [11:0] word,
	output logic [95:0] in_data,
	output logic [7:0] in_word,
	output logic [7:0] in_record,
	output logic [7:0] out_resume
);
	logic [7:0] pend_q;
	logic [3:0] cnt_q;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			in_data <= 96'h0;
			in_word <= 8'h00;
			in_record <= 8'h00;
			out_resume <= 8'h00;
			pend_q <= 8'h00;
			cnt_q <= 4'h0;
		end else begin
			in_word <= 8'h00;
			in_record <= 8'h00;
			out_resume <= 8'h00;
			// word taken: line no longer shows it
			for (int i = 0; i < 8; i++) begin
				if (in_resume[i])
					in_data[i*12 +: 12] <= ~in_data[i*12 +: 12];
			end
			if (send_word) begin
				in_data[chan*12 +: 12] <= word;
				in_word[chan] <= 1'b1;
			end
			if (send_rec)
				in_record[chan] <= 1'b1;
			// only a word asks for a resume; a record pulse restarts the wait
			if (|out_word) begin
				pend_q <= out_word;
				cnt_q <= lag;
			end else if (|out_record && pend_q != 8'h00) begin
				cnt_q <= lag;
			end else if (pend_q != 8'h00) begin
				if (cnt_q == 4'h0) begin
					out_resume <= pend_q;
					pend_q <= 8'h00;
				end else
					cnt_q <= cnt_q - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: sim/pcfc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_regs.vh"
module pcfc_top_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [3:0] lag = 4'hF;
	logic sw = 1'b0;
	logic sr = 1'b0;
	logic [2:0] chan = 3'h0;
	logic [11:0] word = 12'h000;
	logic [31:0] v;
	wire [31:0] rdata;
	wire [95:0] in_data, out_data;
	wire [7:0] in_word, in_rec, in_res, out_word, out_rec, out_res;
	wire perr;
	int num_errors = 0;
	int compares = 0;
	always #10 clk = ~clk;
	pcfc_top dut (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .IN_DATA(in_data), .IN_WORD(in_word), .IN_RECORD(in_rec),
		.IN_RESUME(in_res), .OUT_DATA(out_data), .OUT_WORD(out_word), .OUT_RECORD(out_rec),
		.OUT_RESUME(out_res), .PARITY_ERROR(perr));
	pcfc_partner far (.clk(clk), .rst(rst), .out_word(out_word), .out_record(out_rec),
		.in_resume(in_res), .lag(lag), .send_word(sw), .send_rec(sr), .chan(chan),
		.word(word), .in_data(in_data), .in_word(in_word), .in_record(in_rec),
		.out_resume(out_res));
	task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask
	task automatic wait_idle;
		for (int k = 0; k < 40; k++) begin
			rreg(`PCFC_OFS_STATUS, v);
			if (v[`PCFC_ST_BUSY] === 1'b0)
				return;
		end
		num_errors++;
		tally_and_finish;
	endtask
	task automatic t_reset;
		check("resume_rst", in_res, 8'hFF);
		rst <= 1'b0;
		@(posedge clk);
		rreg(`PCFC_OFS_A, v);
		check("a_rst", v, 32'h0);
		rreg(`PCFC_OFS_FLAGS, v);
		check("flags_rst", v, 32'h0);
		rreg(8'h40, v);
		check("unmapped", v, 32'h0);
	endtask
	task automatic t_send(input logic [5:0] f, input logic [2:0] ch, input logic [5:0] j,
		input logic rec);
		int k;
		wreg(`PCFC_OFS_INSTR, {20'h0, f, 3'h0, ch});
		for (k = 0; k < 10 && (rec ? out_rec : out_word) !== 8'h01 << ch; k++)
			@(negedge clk);
		check("pulse", rec ? out_rec : out_word, 8'h01 << ch);
		check("out_data", out_data[ch*12 +: 12], 12'hABC);
		@(posedge clk);
		wreg(`PCFC_OFS_P, 32'h010);
		wreg(`PCFC_OFS_INSTR, {20'h0, j, 3'h0, ch});
		wait_idle;
		rreg(`PCFC_OFS_P, v);
		check("jump_set", v, 32'h123);
		// a lone record pulse earns no resume; a word clears both flags
		if (rec)
			wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_OUT, 3'h0, ch});
		for (k = 0; k < 40; k++) begin
			rreg(`PCFC_OFS_FLAGS, v);
			if (v[16+8*rec +: 8] === 8'h00)
				break;
		end
		check("flag_clear", v[16+8*rec +: 8], 8'h00);
		check("held", out_data[ch*12 +: 12], 12'hABC);
		wreg(`PCFC_OFS_P, 32'h010);
		wreg(`PCFC_OFS_INSTR, {20'h0, j, 3'h0, ch});
		wait_idle;
		rreg(`PCFC_OFS_P, v);
		check("jump_clear", v, 32'h012);
	endtask
	task automatic t_input(input logic [2:0] ch, input logic [11:0] d);
		int k;
		chan <= ch;
		word <= d;
		sw <= 1'b1;
		sr <= 1'b1;
		@(posedge clk);
		sw <= 1'b0;
		sr <= 1'b0;
		repeat (4) @(posedge clk);
		rreg(`PCFC_OFS_FLAGS, v);
		check("in_flags", v[15:0], {8'h01 << ch, 8'h01 << ch});
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_IN, 3'h0, ch});
		for (k = 0; k < 10 && in_res !== 8'h01 << ch; k++)
			@(negedge clk);
		check("resume", in_res, 8'h01 << ch);
		@(negedge clk);
		check("resume_once", in_res, 8'h00);
		@(posedge clk);
		wait_idle;
		rreg(`PCFC_OFS_A, v);
		check("a_in", v, {20'h0, d});
		rreg(`PCFC_OFS_FLAGS, v);
		check("in_clear", v[15:0], 16'h0);
	endtask
	task automatic t_shift;
		wreg(`PCFC_OFS_A, 32'h20001);
		wreg(`PCFC_OFS_SHIFT, 32'h01);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_SHIFT, 6'h00});
		wait_idle;
		rreg(`PCFC_OFS_A, v);
		check("shift_left", v, 32'h00003);
		wreg(`PCFC_OFS_SHIFT, 32'h21);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_SHIFT, 6'h00});
		wait_idle;
		rreg(`PCFC_OFS_A, v);
		check("shift_right", v, 32'h00001);
	endtask
	task automatic t_mem;
		wreg(`PCFC_OFS_Q, 32'h010);
		wreg(`PCFC_OFS_A, 32'h00005);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_STORE, 6'h00});
		wreg(`PCFC_OFS_Q, 32'h011);
		wreg(`PCFC_OFS_A, 32'h00FFF);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_STORE, 6'h00});
		wreg(`PCFC_OFS_Q, 32'h010);
		wreg(`PCFC_OFS_A, 32'h3FFFF);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_ADD, 6'h00});
		wait_idle;
		check("cycles", v[10:8], 3'h2);
		rreg(`PCFC_OFS_A, v);
		check("a_add", v, 32'h05FFF);
		rreg(`PCFC_OFS_Q, v);
		check("q_upper", v, 32'h005);
		rreg(`PCFC_OFS_X, v);
		check("x_lower", v, 32'h1FFF);
		check("parity", perr, 1'b0);
		// two-word block out on channel 1 from the words just stored
		wreg(`PCFC_OFS_Q, 32'h010);
		wreg(`PCFC_OFS_A, 32'h00002);
		wreg(`PCFC_OFS_INSTR, {20'h0, `PCFC_F_BLK_OUT, 6'h01});
		wait_idle;
		rreg(`PCFC_OFS_A, v);
		check("a_blk", v, 32'h0);
		rreg(`PCFC_OFS_Q, v);
		check("q_blk", v, 32'h012);
		check("blk_data", out_data[23:12], 12'hFFF);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		t_reset;
		wreg(`PCFC_OFS_A, 32'h2ABC);
		wreg(`PCFC_OFS_TARGET, 32'h123);
		t_send(`PCFC_F_OUT, 3'h5, 6'h34, 1'b0);
		t_send(`PCFC_F_REC, 3'h5, 6'h36, 1'b1);
		t_input(3'h3, 12'h5A5);
		t_input(3'h7, 12'hA5A);
		t_shift;
		t_mem;
		tally_and_finish;
	end
endmodule
`default_nettype wire
